// *** shared/obag_pkg.sv ***
// Constants, types and helpers for the operand and branch address block.
// Assumes one core clock; every design file imports this package.
// Function
// RL1: Indexed code read address is data pointer or PC plus accumulator.
// RL2: Indirect RAM address comes from bank register 0 or 1 by opcode bit 0.
// RL3: Immediate operand is the byte after the opcode, used directly.
// RL4: Data pointer load takes the two bytes after the opcode as 16 bits.
// RL5: Relative target is sign-extended last byte plus incremented program counter.
// RL6: Page target uses three opcode bits, second byte and five PC bits.
// RL7: Long target is second byte high, third byte low.
// RL8: Software avoids unimplemented indirect, stack, byte or bit addresses.
// RL9: Accumulator and carry each have one storage, however addressed.
// RL10: A port as move destination gets its output latch written.
// RL11: A port as transfer or two-operand source reads the pins.
// RL12: Read-modify-write on a port reads its latch.
// RL13: A port bit write changes only that pin's latch bit.
// RL14: A port bit as Boolean source reads the pin.
// RL15: Bit complement and jump-if-set-then-clear read the latch.
// RL16: Parity in status bit 0 is recomputed every cycle; writes never stick.
// RL17: Priority bits 7 to 5 and enable bits 6 and 5 are reserved.
// RL18: Interrupt request to handler takes 38 to 81 oscillator periods.
// RL19: Writes to the status word byte or bits change the flags directly.
// RL20: Bank from status bits 4 and 3, register from opcode low bits.
// RL21: Direct bytes 0 to 127 are RAM, 128 to 255 special registers.
// RL22: Direct bits from 128 use five high bits as register, three as position.
// RL23: Incremented PC is the address after the whole branch instruction.
// RL24: Direct bits 0 to 127 live in RAM bytes 32 to 47, LSB first.
`default_nettype none
package obag_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned NUM_PORTS = 4;
  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_IE = 8'ha8;
  localparam logic [7:0] SFR_IP = 8'hb8;
  localparam logic [7:0] SFR_PORT_BASE = 8'h80;
  localparam logic [7:0] SFR_PORT_MASK = 8'hcf;
  localparam int PORT_IDX_LSB = 4;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam int PSW_CARRY_BIT = 7;
  localparam int PSW_BANK_LSB = 3;
  localparam int PSW_PARITY_BIT = 0;
  localparam int IE_GLOBAL_BIT = 7;
  localparam logic [7:0] IE_IMPL_MASK = 8'h9f;
  localparam logic [7:0] IP_IMPL_MASK = 8'h1f;
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam int unsigned OSC_PER_CLK = 1;
  localparam int unsigned IRQ_LAT_MIN_OSC = 38;
  localparam int unsigned IRQ_LAT_MAX_OSC = 81;
  localparam int unsigned IRQ_LAT_MIN_CYC = (IRQ_LAT_MIN_OSC + OSC_PER_CLK - 1) / OSC_PER_CLK;
  localparam int unsigned IRQ_LAT_MAX_CYC = IRQ_LAT_MAX_OSC / OSC_PER_CLK;

  typedef enum logic [4:0] {
    OBAG_OP_CODE_DATA_POINTER, OBAG_OP_CODE_PC, OBAG_OP_INDIRECT, OBAG_OP_REGISTER,
    OBAG_OP_IMMEDIATE, OBAG_OP_LOAD_DATA_POINTER, OBAG_OP_REL, OBAG_OP_ABS, OBAG_OP_LONG,
    OBAG_OP_DIR_READ, OBAG_OP_DIR_RMW, OBAG_OP_DIR_WRITE, OBAG_OP_BIT_READ,
    OBAG_OP_BIT_RMW, OBAG_OP_BIT_WRITE, OBAG_OP_ACC_WRITE, OBAG_OP_CARRY_WRITE
  } obag_op_t;

  typedef enum logic [3:0] {
    OBAG_RG_RAM, OBAG_RG_ACC, OBAG_RG_PSW, OBAG_RG_DPL, OBAG_RG_DPH,
    OBAG_RG_PORT, OBAG_RG_IE, OBAG_RG_IP, OBAG_RG_OTHER
  } obag_region_t;

  function automatic logic [7:0] obag_bank_reg(input logic [1:0] bank, input logic [2:0] rn);
    return {3'h0, bank, rn};
  endfunction

  function automatic logic [7:0] obag_put_bit(input logic [7:0] v, input logic [2:0] pos, input logic b);
    logic [7:0] r;
    r = v;
    r[pos] = b;
    return r;
  endfunction
endpackage
`default_nettype wire

// *** src/obag_branch_calc.sv ***
// Branch target arithmetic for relative, page and long branches.
// Assumes the caller supplies the branch's first byte address and length.
`default_nettype none
module obag_branch_calc (
  input wire obag_pkg::obag_op_t kind,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] instr_pc,
  input wire logic [1:0] instr_len,
  output logic [15:0] pc_next,
  output logic [15:0] target
);
  import obag_pkg::*;
  logic [7:0] disp;

  always_comb begin
    pc_next = instr_pc + {14'h0000, instr_len}; // [RL23]
    // The displacement is always the last byte, which moves with the length.
    disp = (instr_len == 2'h3) ? byte3 : byte2;
    case (kind)
      OBAG_OP_REL: target = pc_next + {{8{disp[7]}}, disp}; // [RL5]
      OBAG_OP_ABS: target = {pc_next[15:11], opcode[7:5], byte2}; // [RL6]
      OBAG_OP_LONG: target = {byte2, byte3}; // [RL7]
      default: target = pc_next;
    endcase
  end
endmodule
`default_nettype wire

// *** src/obag_direct_decode.sv ***
// Decoder for direct byte and direct bit addresses.
// Assumes the address is the second instruction byte.
`default_nettype none
module obag_direct_decode (
  input wire logic [7:0] addr,
  input wire logic is_bit,
  output obag_pkg::obag_region_t region,
  output logic [7:0] byte_addr,
  output logic [2:0] bit_pos,
  output logic [1:0] port_idx
);
  import obag_pkg::*;

  always_comb begin
    bit_pos = is_bit ? addr[2:0] : 3'h0;
    if (!is_bit) begin
      byte_addr = addr;
    end else if (!addr[7]) begin
      byte_addr = BIT_RAM_BASE + {4'h0, addr[6:3]}; // [RL24]
    end else begin
      byte_addr = {addr[7:3], 3'h0}; // [RL22]
    end
    port_idx = byte_addr[PORT_IDX_LSB +: 2];
    if (!byte_addr[7]) begin
      region = OBAG_RG_RAM; // [RL21]
    end else if ((byte_addr & SFR_PORT_MASK) == SFR_PORT_BASE) begin
      region = OBAG_RG_PORT;
    end else begin
      case (byte_addr)
        SFR_ACC: region = OBAG_RG_ACC;
        SFR_PSW: region = OBAG_RG_PSW;
        SFR_DPL: region = OBAG_RG_DPL;
        SFR_DPH: region = OBAG_RG_DPH;
        SFR_IE: region = OBAG_RG_IE;
        SFR_IP: region = OBAG_RG_IP;
        default: region = OBAG_RG_OTHER;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** src/obag_top.sv ***
// Operand and branch address generation with accumulator, carry, status word,
// data pointer, port latches, interrupt control bytes and interrupt latency.
// Assumes RAM, other special registers and code memory answer with a valid strobe.
`default_nettype none
module obag_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire obag_pkg::obag_op_t op_kind,
  input wire logic [7:0] opcode,
  input wire logic [7:0] byte2,
  input wire logic [7:0] byte3,
  input wire logic [15:0] instr_pc,
  input wire logic [1:0] instr_len,
  input wire logic [7:0] wr_data,
  input wire logic bit_value,
  input wire logic [31:0] port_pins,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  input wire logic code_rvalid,
  input wire logic [7:0] code_rdata,
  input wire logic irq_req,
  input wire logic instr_done,
  output logic busy,
  output logic result_valid,
  output logic [7:0] result_value,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_sfr,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_bit,
  output logic [2:0] mem_bit_pos,
  output logic code_rd,
  output logic [15:0] code_addr,
  output logic branch_valid,
  output logic [15:0] branch_target,
  output logic [15:0] data_pointer,
  output logic [7:0] accumulator,
  output logic [7:0] program_status_word,
  output logic [31:0] port_latch,
  output logic [7:0] int_enable,
  output logic [7:0] interrupt_priority_reg,
  output logic irq_take
);
  import obag_pkg::*;

  typedef enum {OBAG_IDLE, OBAG_PTR_WAIT, OBAG_CODE_WAIT} obag_state_t;

  obag_state_t state_ff, nxt_state;
  logic busy_ff, nxt_busy;
  logic result_valid_ff, nxt_result_valid;
  logic [7:0] result_value_ff, nxt_result_value;
  logic mem_rd_ff, nxt_mem_rd;
  logic mem_wr_ff, nxt_mem_wr;
  logic mem_sfr_ff, nxt_mem_sfr;
  logic [7:0] mem_addr_ff, nxt_mem_addr;
  logic [7:0] mem_wdata_ff, nxt_mem_wdata;
  logic mem_bit_ff, nxt_mem_bit;
  logic [2:0] mem_bit_pos_ff, nxt_mem_bit_pos;
  logic code_rd_ff, nxt_code_rd;
  logic [15:0] code_addr_ff, nxt_code_addr;
  logic branch_valid_ff, nxt_branch_valid;
  logic [15:0] branch_target_ff, nxt_branch_target;
  logic [15:0] data_pointer_ff, nxt_data_pointer;
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] psw_ff, nxt_psw;
  logic [31:0] port_latch_ff, nxt_port_latch;
  logic [7:0] ie_ff, nxt_ie;
  logic [7:0] ip_ff, nxt_ip;
  logic irq_pend_ff, nxt_irq_pend;
  logic [6:0] irq_cnt_ff, nxt_irq_cnt;
  logic irq_take_ff, nxt_irq_take;

  obag_region_t dd_region;
  logic [7:0] dd_addr;
  logic [2:0] dd_pos;
  logic [1:0] dd_port;
  logic dd_is_bit;
  logic use_latch;
  logic is_local;
  logic [7:0] loc_cur;
  logic [7:0] rd_val;
  logic [7:0] new_byte;
  logic [15:0] bc_pc_next;
  logic [15:0] bc_target;
  logic op_take;

  assign dd_is_bit = (op_kind == OBAG_OP_BIT_READ) || (op_kind == OBAG_OP_BIT_RMW) ||
                     (op_kind == OBAG_OP_BIT_WRITE);
  assign use_latch = (op_kind == OBAG_OP_DIR_RMW) || (op_kind == OBAG_OP_BIT_RMW); // [RL12] [RL15]
  assign op_take = clk_en && op_valid && (state_ff == OBAG_IDLE);

  obag_direct_decode u_decode (
    .addr(byte2),
    .is_bit(dd_is_bit),
    .region(dd_region),
    .byte_addr(dd_addr),
    .bit_pos(dd_pos),
    .port_idx(dd_port)
  );

  obag_branch_calc u_branch (
    .kind(op_kind),
    .opcode(opcode),
    .byte2(byte2),
    .byte3(byte3),
    .instr_pc(instr_pc),
    .instr_len(instr_len),
    .pc_next(bc_pc_next),
    .target(bc_target)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_result_valid = 1'b0;
    nxt_result_value = result_value_ff;
    nxt_mem_rd = 1'b0;
    nxt_mem_wr = 1'b0;
    nxt_mem_sfr = mem_sfr_ff;
    nxt_mem_addr = mem_addr_ff;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_mem_bit = mem_bit_ff;
    nxt_mem_bit_pos = mem_bit_pos_ff;
    nxt_code_rd = 1'b0;
    nxt_code_addr = code_addr_ff;
    nxt_branch_valid = 1'b0;
    nxt_branch_target = branch_target_ff;
    nxt_data_pointer = data_pointer_ff;
    nxt_acc = acc_ff;
    nxt_psw = psw_ff;
    nxt_port_latch = port_latch_ff;
    nxt_ie = ie_ff;
    nxt_ip = ip_ff;
    case (dd_region)
      OBAG_RG_ACC: loc_cur = acc_ff;
      OBAG_RG_PSW: loc_cur = psw_ff;
      OBAG_RG_DPL: loc_cur = data_pointer_ff[7:0];
      OBAG_RG_DPH: loc_cur = data_pointer_ff[15:8];
      OBAG_RG_PORT: loc_cur = port_latch_ff[dd_port * 8 +: 8];
      OBAG_RG_IE: loc_cur = ie_ff;
      OBAG_RG_IP: loc_cur = ip_ff;
      default: loc_cur = 8'h00;
    endcase
    is_local = (dd_region != OBAG_RG_RAM) && (dd_region != OBAG_RG_OTHER);
    // Plain sources see the pins; read-modify-write sources see the latch.
    if ((dd_region == OBAG_RG_PORT) && !use_latch) begin
      rd_val = port_pins[dd_port * 8 +: 8]; // [RL11] [RL14]
    end else begin
      rd_val = loc_cur;
    end
    new_byte = dd_is_bit ? obag_put_bit(loc_cur, dd_pos, bit_value) : wr_data; // [RL13]
    case (state_ff)
      OBAG_IDLE: begin
        if (op_valid) begin
          case (op_kind)
            OBAG_OP_CODE_DATA_POINTER, OBAG_OP_CODE_PC: begin
              nxt_code_addr = ((op_kind == OBAG_OP_CODE_DATA_POINTER) ? data_pointer_ff : bc_pc_next) +
                              {8'h00, acc_ff}; // [RL1]
              nxt_code_rd = 1'b1;
              nxt_state = OBAG_CODE_WAIT;
            end
            OBAG_OP_INDIRECT: begin
              nxt_mem_addr = obag_bank_reg(psw_ff[PSW_BANK_LSB +: 2], {2'h0, opcode[0]}); // [RL2]
              nxt_mem_sfr = 1'b0;
              nxt_mem_bit = 1'b0;
              nxt_mem_rd = 1'b1;
              nxt_state = OBAG_PTR_WAIT;
            end
            OBAG_OP_REGISTER: begin
              nxt_mem_addr = obag_bank_reg(psw_ff[PSW_BANK_LSB +: 2], opcode[2:0]); // [RL20]
              nxt_mem_sfr = 1'b0;
              nxt_mem_bit = 1'b0;
              nxt_mem_rd = 1'b1;
            end
            OBAG_OP_IMMEDIATE: begin
              nxt_result_value = byte2; // [RL3]
              nxt_result_valid = 1'b1;
            end
            OBAG_OP_LOAD_DATA_POINTER: nxt_data_pointer = {byte2, byte3}; // [RL4]
            OBAG_OP_REL, OBAG_OP_ABS, OBAG_OP_LONG: begin
              nxt_branch_target = bc_target; // [RL5] [RL6] [RL7]
              nxt_branch_valid = 1'b1;
            end
            OBAG_OP_DIR_READ, OBAG_OP_DIR_RMW, OBAG_OP_BIT_READ, OBAG_OP_BIT_RMW: begin
              if (is_local) begin
                nxt_result_value = dd_is_bit ? {7'h00, rd_val[dd_pos]} : rd_val;
                nxt_result_valid = 1'b1;
              end else begin
                nxt_mem_addr = dd_addr;
                nxt_mem_sfr = (dd_region == OBAG_RG_OTHER);
                nxt_mem_bit = dd_is_bit;
                nxt_mem_bit_pos = dd_pos;
                nxt_mem_rd = 1'b1;
              end
            end
            OBAG_OP_DIR_WRITE, OBAG_OP_BIT_WRITE: begin
              case (dd_region)
                OBAG_RG_ACC: nxt_acc = new_byte; // [RL9]
                OBAG_RG_PSW: nxt_psw = new_byte; // [RL19] [RL9]
                OBAG_RG_DPL: nxt_data_pointer[7:0] = new_byte;
                OBAG_RG_DPH: nxt_data_pointer[15:8] = new_byte;
                OBAG_RG_PORT: nxt_port_latch[dd_port * 8 +: 8] = new_byte; // [RL10] [RL13]
                OBAG_RG_IE: nxt_ie = new_byte & IE_IMPL_MASK; // [RL17]
                OBAG_RG_IP: nxt_ip = new_byte & IP_IMPL_MASK; // [RL17]
                default: begin
                  nxt_mem_addr = dd_addr;
                  nxt_mem_sfr = (dd_region == OBAG_RG_OTHER);
                  nxt_mem_bit = dd_is_bit;
                  nxt_mem_bit_pos = dd_pos;
                  nxt_mem_wdata = dd_is_bit ? {7'h00, bit_value} : wr_data;
                  nxt_mem_wr = 1'b1;
                end
              endcase
            end
            OBAG_OP_ACC_WRITE: nxt_acc = wr_data; // [RL9]
            OBAG_OP_CARRY_WRITE: nxt_psw[PSW_CARRY_BIT] = bit_value; // [RL9]
            default: nxt_state = OBAG_IDLE;
          endcase
        end
      end
      OBAG_PTR_WAIT: begin
        if (mem_rvalid) begin
          // The pointer reaches all 256 RAM locations, never the special registers.
          nxt_mem_addr = mem_rdata; // [RL2]
          nxt_mem_sfr = 1'b0;
          nxt_mem_rd = 1'b1;
          nxt_result_value = mem_rdata;
          nxt_result_valid = 1'b1;
          nxt_state = OBAG_IDLE;
        end
      end
      OBAG_CODE_WAIT: begin
        if (code_rvalid) begin
          nxt_acc = code_rdata; // [RL1]
          nxt_result_value = code_rdata;
          nxt_result_valid = 1'b1;
          nxt_state = OBAG_IDLE;
        end
      end
      default: nxt_state = OBAG_IDLE;
    endcase
    // Recomputed last so that any store into the status word loses the parity bit.
    nxt_psw[PSW_PARITY_BIT] = ^nxt_acc; // [RL16]
    nxt_busy = (nxt_state != OBAG_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= OBAG_IDLE;
      busy_ff <= 1'b0;
      result_valid_ff <= 1'b0;
      result_value_ff <= 8'h00;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_sfr_ff <= 1'b0;
      mem_addr_ff <= 8'h00;
      mem_wdata_ff <= 8'h00;
      mem_bit_ff <= 1'b0;
      mem_bit_pos_ff <= 3'h0;
      code_rd_ff <= 1'b0;
      code_addr_ff <= 16'h0000;
      branch_valid_ff <= 1'b0;
      branch_target_ff <= 16'h0000;
      data_pointer_ff <= 16'h0000;
      acc_ff <= 8'h00;
      psw_ff <= 8'h00;
      port_latch_ff <= {NUM_PORTS{PORT_RST}};
      ie_ff <= 8'h00;
      ip_ff <= 8'h00;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      busy_ff <= nxt_busy;
      result_valid_ff <= nxt_result_valid;
      result_value_ff <= nxt_result_value;
      mem_rd_ff <= nxt_mem_rd;
      mem_wr_ff <= nxt_mem_wr;
      mem_sfr_ff <= nxt_mem_sfr;
      mem_addr_ff <= nxt_mem_addr;
      mem_wdata_ff <= nxt_mem_wdata;
      mem_bit_ff <= nxt_mem_bit;
      mem_bit_pos_ff <= nxt_mem_bit_pos;
      code_rd_ff <= nxt_code_rd;
      code_addr_ff <= nxt_code_addr;
      branch_valid_ff <= nxt_branch_valid;
      branch_target_ff <= nxt_branch_target;
      data_pointer_ff <= nxt_data_pointer;
      acc_ff <= nxt_acc;
      psw_ff <= nxt_psw;
      port_latch_ff <= nxt_port_latch;
      ie_ff <= nxt_ie;
      ip_ff <= nxt_ip;
    end
  end

  // Latency counts from the cycle the request is seen; the handover waits for the
  // instruction boundary but is forced at the upper bound so no request starves.
  always_comb begin
    nxt_irq_pend = irq_pend_ff;
    nxt_irq_cnt = irq_cnt_ff;
    nxt_irq_take = 1'b0;
    if (!irq_pend_ff) begin
      if (irq_req && ie_ff[IE_GLOBAL_BIT]) begin
        nxt_irq_pend = 1'b1;
        nxt_irq_cnt = 7'h01;
      end
    end else begin
      nxt_irq_cnt = irq_cnt_ff + 7'h01;
      if ((instr_done && (irq_cnt_ff >= 7'(IRQ_LAT_MIN_CYC - 1))) ||
          (irq_cnt_ff == 7'(IRQ_LAT_MAX_CYC - 1))) begin // [RL18]
        nxt_irq_take = 1'b1;
        nxt_irq_pend = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_pend_ff <= 1'b0;
      irq_cnt_ff <= 7'h00;
      irq_take_ff <= 1'b0;
    end else if (clk_en) begin
      irq_pend_ff <= nxt_irq_pend;
      irq_cnt_ff <= nxt_irq_cnt;
      irq_take_ff <= nxt_irq_take;
    end
  end

  assign busy = busy_ff;
  assign result_valid = result_valid_ff;
  assign result_value = result_value_ff;
  assign mem_rd = mem_rd_ff;
  assign mem_wr = mem_wr_ff;
  assign mem_sfr = mem_sfr_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_bit = mem_bit_ff;
  assign mem_bit_pos = mem_bit_pos_ff;
  assign code_rd = code_rd_ff;
  assign code_addr = code_addr_ff;
  assign branch_valid = branch_valid_ff;
  assign branch_target = branch_target_ff;
  assign data_pointer = data_pointer_ff;
  assign accumulator = acc_ff;
  assign program_status_word = psw_ff;
  assign port_latch = port_latch_ff;
  assign int_enable = ie_ff;
  assign interrupt_priority_reg = ip_ff;
  assign irq_take = irq_take_ff;

  localparam int A_LAT_LO = 37;
  localparam int A_LAT_HI = 80;

  sequence s_indirect_issue;
    op_take && (op_kind == OBAG_OP_INDIRECT);
  endsequence
  sequence s_ptr_returned;
    (state_ff == OBAG_PTR_WAIT) && mem_rvalid && clk_en;
  endsequence

  a_parity_tracks_acc: assert property (@(posedge core_clk) disable iff (rst) // [RL16]
    psw_ff[PSW_PARITY_BIT] == ^acc_ff) else $error("parity bit differs from accumulator parity");
  a_code_index_sum: assert property (@(posedge core_clk) disable iff (rst) // [RL1]
    op_take && (op_kind == OBAG_OP_CODE_DATA_POINTER) |=> code_rd_ff && busy_ff &&
    (code_addr_ff == $past(data_pointer_ff) + {8'h00, $past(acc_ff)})) else $error("indexed code address wrong");
  a_indirect_ptr_sel: assert property (@(posedge core_clk) disable iff (rst) // [RL2]
    s_indirect_issue |=> mem_rd_ff && !mem_sfr_ff &&
    (mem_addr_ff == {3'h0, $past(psw_ff[4:3]), 2'h0, $past(opcode[0])})) else $error("pointer register wrong");
  a_indirect_final: assert property (@(posedge core_clk) disable iff (rst) // [RL2]
    s_ptr_returned |=> mem_rd_ff && result_valid_ff && !busy_ff &&
    (mem_addr_ff == $past(mem_rdata))) else $error("indirect address not taken from pointer");
  a_immediate_value: assert property (@(posedge core_clk) disable iff (rst) // [RL3]
    op_take && (op_kind == OBAG_OP_IMMEDIATE) |=> result_valid_ff &&
    (result_value_ff == $past(byte2))) else $error("immediate operand wrong");
  a_data_pointer_load: assert property (@(posedge core_clk) disable iff (rst) // [RL4]
    op_take && (op_kind == OBAG_OP_LOAD_DATA_POINTER) |=> data_pointer_ff == {$past(byte2), $past(byte3)})
    else $error("data pointer load wrong");
  a_rel_target: assert property (@(posedge core_clk) disable iff (rst) // [RL5]
    op_take && (op_kind == OBAG_OP_REL) && (instr_len == 2'h2) |=> branch_valid_ff &&
    (branch_target_ff == $past(instr_pc) + 16'h0002 + {{8{$past(byte2[7])}}, $past(byte2)}))
    else $error("relative target wrong");
  a_abs_page: assert property (@(posedge core_clk) disable iff (rst) // [RL6]
    op_take && (op_kind == OBAG_OP_ABS) |=> branch_valid_ff &&
    (branch_target_ff[10:0] == {$past(opcode[7:5]), $past(byte2)}) &&
    ((branch_target_ff ^ ($past(instr_pc) + {14'h0000, $past(instr_len)})) < 16'h0800))
    else $error("page target wrong");
  a_long_target: assert property (@(posedge core_clk) disable iff (rst) // [RL7]
    op_take && (op_kind == OBAG_OP_LONG) |=> branch_target_ff == {$past(byte2), $past(byte3)})
    else $error("long target wrong");
  a_port_pin_read: assert property (@(posedge core_clk) disable iff (rst) // [RL11]
    op_take && (op_kind == OBAG_OP_DIR_READ) && (dd_region == OBAG_RG_PORT) |=>
    result_value_ff == $past(port_pins[dd_port * 8 +: 8])) else $error("port read did not see pins");
  a_port_rmw_latch: assert property (@(posedge core_clk) disable iff (rst) // [RL12]
    op_take && (op_kind == OBAG_OP_DIR_RMW) && (dd_region == OBAG_RG_PORT) |=>
    result_value_ff == $past(port_latch_ff[dd_port * 8 +: 8])) else $error("port rmw did not see latch");
  a_bit_write_one: assert property (@(posedge core_clk) disable iff (rst) // [RL13]
    op_take && (op_kind == OBAG_OP_BIT_WRITE) && (dd_region == OBAG_RG_PORT) |=>
    (port_latch_ff ^ $past(port_latch_ff)) == (32'h0 |
    ({31'h0, $past(bit_value) ^ $past(loc_cur[dd_pos])} << ($past(dd_port) * 8 + $past(dd_pos)))))
    else $error("port bit write touched other bits");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst) // [RL17]
    (ie_ff[6:5] == 2'h0) && (ip_ff[7:5] == 3'h0)) else $error("reserved interrupt bits set");
  a_irq_window: assert property (@(posedge core_clk) disable iff (rst) // [RL18]
    clk_en && irq_req && !irq_pend_ff && ie_ff[IE_GLOBAL_BIT] && !irq_take_ff |=>
    ##[A_LAT_LO:A_LAT_HI] irq_take_ff) else $error("interrupt latency out of window");
  a_irq_not_early: assert property (@(posedge core_clk) disable iff (rst) // [RL18]
    $rose(irq_take_ff) |-> $past(irq_cnt_ff) >= 7'h25) else $error("interrupt taken too early");
endmodule
`default_nettype wire

// *** bench/obag_top_tb.sv ***
// Self-checking bench for the operand and branch address block, driving every port itself.
// Assumes obag_pkg and the design sources are compiled first; one 20 MHz core clock.
`default_nettype none
module obag_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import obag_pkg::*;
  typedef struct {obag_op_t k; logic [7:0] opc, b2, b3, wd; logic [15:0] pc; logic [1:0] len; logic [15:0] exp;} obag_row_t;
  logic core_clk = '0, rst = '1, clk_en = '1, op_valid = '0, bit_value = '0, mem_rvalid = '0, code_rvalid = '0;
  logic irq_req = '0, instr_done = '0, busy, result_valid, mem_rd, mem_wr, mem_sfr, mem_bit, code_rd, branch_valid;
  logic irq_take;
  obag_op_t op_kind = OBAG_OP_IMMEDIATE;
  logic [7:0] opcode = '0, byte2 = '0, byte3 = '0, wr_data = '0, mem_rdata = '0, code_rdata = '0;
  logic [7:0] result_value, mem_addr, mem_wdata, accumulator, program_status_word, int_enable, interrupt_priority_reg;
  logic [1:0] instr_len = 2'h2;
  logic [2:0] mem_bit_pos;
  logic [15:0] instr_pc = '0, code_addr, branch_target, data_pointer;
  logic [31:0] port_pins = 32'h0000_a500, port_latch;
  int bad_count = 0, n_compared = 0, cyc = 0, n;
  // Every address used below names an implemented location or register.
  obag_row_t rows[7] = '{
    '{OBAG_OP_REL, 8'h00, 8'h80, 8'h00, 8'h00, 16'h0100, 2'h2, 16'h0082},
    '{OBAG_OP_REL, 8'h00, 8'h00, 8'h7f, 8'h00, 16'h1000, 2'h3, 16'h1082},
    '{OBAG_OP_ABS, 8'he1, 8'h34, 8'h00, 8'h00, 16'h07fe, 2'h2, 16'h0f34},
    '{OBAG_OP_LONG, 8'h00, 8'h12, 8'h34, 8'h00, 16'h0000, 2'h3, 16'h1234},
    '{OBAG_OP_IMMEDIATE, 8'h00, 8'h5a, 8'h00, 8'h00, 16'h0000, 2'h2, 16'h005a},
    '{OBAG_OP_BIT_READ, 8'h00, 8'h0a, 8'h00, 8'h00, 16'h0000, 2'h2, 16'h0021},
    '{OBAG_OP_DIR_READ, 8'h00, 8'h89, 8'h00, 8'h00, 16'h0000, 2'h2, 16'h0089}};
  obag_top dut (.*);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic issue(input obag_row_t r);
    @(posedge core_clk);
    op_kind <= r.k;
    opcode <= r.opc;
    byte2 <= r.b2;
    byte3 <= r.b3;
    wr_data <= r.wd;
    bit_value <= r.wd[0];
    instr_pc <= r.pc;
    instr_len <= r.len;
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic op(input obag_op_t k, input logic [7:0] b2, input logic [7:0] x);
    issue('{k, 8'h01, b2, x, x, 16'h0000, 2'h2, 16'h0000});
  endtask
  // Only the unit in its wait state listens, so both strobes can be raised together.
  task automatic reply(input logic [7:0] d);
    @(posedge core_clk);
    code_rvalid <= 1'b1;
    mem_rvalid <= 1'b1;
    code_rdata <= d;
    mem_rdata <= d;
    @(posedge core_clk);
    code_rvalid <= 1'b0;
    mem_rvalid <= 1'b0;
    #1;
  endtask
  task automatic wait_take(output int w);
    w = 0;
    do begin
      @(posedge core_clk);
      w++;
      #1;
    end while (irq_take !== 1'b1 && w < 100);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("latch", 32'hffffffff, port_latch);
    chk("data_pointer", 32'h0, data_pointer);
    foreach (rows[i]) begin
      issue(rows[i]);
      chk("row", rows[i].exp, (rows[i].k inside {OBAG_OP_REL, OBAG_OP_ABS, OBAG_OP_LONG}) ? branch_target :
          (rows[i].k == OBAG_OP_IMMEDIATE) ? {8'h00, result_value} : {8'h00, mem_addr});
      chk("bv", rows[i].k inside {OBAG_OP_REL, OBAG_OP_ABS, OBAG_OP_LONG}, branch_valid);
    end
    op(OBAG_OP_LOAD_DATA_POINTER, 8'h12, 8'h34);
    chk("data_pointer", 32'h1234, data_pointer);
    op(OBAG_OP_ACC_WRITE, 8'h00, 8'h07);
    chk("psw", 32'h01, program_status_word);
    op(OBAG_OP_DIR_READ, 8'he0, 8'h00);
    chk("acc", 32'h07, result_value);
    op(OBAG_OP_CODE_DATA_POINTER, 8'h00, 8'h00);
    chk("caddr", 32'h123b, code_addr);
    chk("strb", 32'h24, {busy, result_valid, branch_valid, code_rd, mem_rd, mem_wr});
    reply(8'h3c);
    chk("acc", 32'h3c, accumulator);
    op(OBAG_OP_CODE_PC, 8'h00, 8'h00);
    chk("caddr", 32'h003e, code_addr);
    reply(8'h3c);
    op(OBAG_OP_INDIRECT, 8'h00, 8'h00);
    chk("iaddr", 32'h01, mem_addr);
    reply(8'h44);
    chk("ival", 32'h44, result_value);
    chk("strb", 32'h12, {busy, result_valid, branch_valid, code_rd, mem_rd, mem_wr});
    op(OBAG_OP_DIR_WRITE, 8'hd0, 8'h18);
    chk("psw", 32'h18, program_status_word);
    op(OBAG_OP_REGISTER, 8'h00, 8'h00);
    chk("raddr", 32'h19, mem_addr);
    op(OBAG_OP_DIR_WRITE, 8'h90, 8'h0f);
    chk("latch", 32'h0f, port_latch[15:8]);
    op(OBAG_OP_DIR_READ, 8'h90, 8'h00);
    chk("pins", 32'ha5, result_value);
    op(OBAG_OP_DIR_RMW, 8'h90, 8'h00);
    chk("rmw", 32'h0f, result_value);
    op(OBAG_OP_BIT_WRITE, 8'h94, 8'h01);
    chk("latch", 32'h1f, port_latch[15:8]);
    op(OBAG_OP_BIT_READ, 8'h91, 8'h00);
    chk("pinbit", 32'h00, result_value);
    op(OBAG_OP_BIT_RMW, 8'h91, 8'h00);
    chk("latbit", 32'h01, result_value);
    op(OBAG_OP_DIR_WRITE, 8'ha8, 8'hff);
    chk("ie", 32'h9f, int_enable);
    op(OBAG_OP_DIR_WRITE, 8'hb8, 8'hff);
    chk("ip", 32'h1f, interrupt_priority_reg);
    op(OBAG_OP_CARRY_WRITE, 8'h00, 8'h01);
    op(OBAG_OP_BIT_READ, 8'hd7, 8'h00);
    chk("carry", 32'h01, result_value);
    op(OBAG_OP_BIT_WRITE, 8'h0a, 8'h01);
    chk("memwr", 32'h2a0121, {mem_wr, mem_sfr, mem_bit, mem_bit_pos, mem_wdata, mem_addr});
    @(posedge core_clk);
    irq_req <= 1'b1;
    instr_done <= 1'b1;
    wait_take(n);
    chk("irqmin", 32'h26, n);
    // The request is still high at the next edge, so a second count starts there.
    @(posedge core_clk);
    irq_req <= 1'b0;
    instr_done <= 1'b0;
    wait_take(n);
    chk("irqmax", 32'h50, n);
    complete_run();
  end
endmodule
`default_nettype wire
